// [include/cell_bank_pkg.sv]
// Constants, register map and carrier types of the logic cell bank.
package cell_bank_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int NCELL = 4;
    localparam int NSRC = 8;
    localparam int NGATE = 4;
    localparam int ADDR_W = 8;
    localparam int SEL_W = 3;

    // The fast internal oscillator is source index seven.
    localparam logic [2:0] SRC_FAST_OSC = 3'h7;

    // ==========================================================
    // Register map, byte addresses
    // ==========================================================
    localparam logic [7:0] ADDR_INTCTL = 8'h00;
    localparam logic [7:0] ADDR_FLAG = 8'h04;
    localparam logic [7:0] ADDR_IEN = 8'h08;
    localparam logic [7:0] ADDR_MIRROR = 8'h0C;
    localparam logic [7:0] CELL_BASE = 8'h10;
    localparam logic [7:0] CELL_STRIDE = 8'h10;
    localparam logic [1:0] OFS_CTRL = 2'h0;
    localparam logic [1:0] OFS_SEL = 2'h1;
    localparam logic [1:0] OFS_GLS = 2'h2;
    localparam logic [1:0] OFS_POL = 2'h3;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int INTCTL_GIE = 0;
    localparam int INTCTL_PERIPHERAL_IRQ_ENABLE = 1;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FALL = 3;
    localparam int CTRL_RISE = 4;
    localparam int CTRL_OUT = 5;
    localparam int CTRL_EN = 7;
    localparam int POL_OUT = 7;

    // ==========================================================
    // Reset values and responses
    // ==========================================================
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [NCELL-1:0] FLAG_RESET = 4'h0;
    localparam logic [NCELL-1:0] IEN_RESET = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Logic function codes
    // ==========================================================
    localparam logic [2:0] MODE_AND_OR = 3'h0;
    localparam logic [2:0] MODE_OR_XOR = 3'h1;
    localparam logic [2:0] MODE_AND4 = 3'h2;
    localparam logic [2:0] MODE_OR4 = 3'h3;
    localparam logic [2:0] MODE_XOR4 = 3'h4;

    typedef struct packed {
        logic enable;
        logic rise_irq_enable;
        logic fall_irq_enable;
        logic [2:0] logic_function_field;
    } cell_ctrl_t;

    typedef struct packed {
        logic [NGATE-1:0][SEL_W-1:0] input_select;
        logic [NGATE-1:0][3:0] gate_source;
        logic [NGATE-1:0] gate_invert_bit;
        logic output_invert_bit;
    } cell_route_t;

endpackage

// [logic/logic_cell.sv]
// One clockless configurable logic cell: select, gate, function, polarity.
`timescale 1ns/1ps
module logic_cell (
    input wire logic [cell_bank_pkg::NSRC-1:0] src,
    input wire cell_bank_pkg::cell_ctrl_t ctrl,
    input wire cell_bank_pkg::cell_route_t route,
    output logic y
);
    import cell_bank_pkg::*;

    logic [NGATE-1:0] data;
    logic [NGATE-1:0] gate;
    logic f;

    // ==========================================================
    // Input select and gates
    // ==========================================================
    // [RULE_08] Pure combinational path.
    always_comb begin
        for (int k = 0; k < NGATE; k++) begin
            data[k] = src[route.input_select[k]];
        end
        for (int g = 0; g < NGATE; g++) begin
            gate[g] = (|(data & route.gate_source[g])) ^
                route.gate_invert_bit[g];
        end
    end

    // ==========================================================
    // Logic function
    // ==========================================================
    always_comb begin
        case (ctrl.logic_function_field)
            MODE_AND_OR: f = (gate[0] & gate[1]) | (gate[2] & gate[3]);
            MODE_OR_XOR: f = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
            MODE_AND4: f = &gate;
            MODE_OR4: f = |gate;
            MODE_XOR4: f = ^gate;
            default: f = 1'b0;
        endcase
    end

    assign y = ctrl.enable & (f ^ route.output_invert_bit);

endmodule

// [logic/cell_bank.sv]
// Logic cell bank with edge interrupts, output mirror and AXI4-Lite slave.
// What this block does
// [RULE_01] Each cell detects rising and falling output edges.
// [RULE_02] Enabled edge sets the cell interrupt flag.
// [RULE_03] Software alone clears the interrupt flag.
// [RULE_04] Edge set beats simultaneous software clear.
// [RULE_05] Interrupt needs cell, peripheral, global enables.
// [RULE_06] Mirror register reads all outputs together.
// [RULE_07] Reset clears control, keeps selects and polarity.
// [RULE_08] Cells run without the system clock.
// [RULE_09] Enabled cell using fast oscillator keeps it running.
// [RULE_10] Configure a cell while disabled, enable last.
// [RULE_11] Pin routing and direction set by software; this block has no pin routing, cell_output_bit drives the ports directly.
// [RULE_12] Edges found against previous registered output.
`timescale 1ns/1ps
module cell_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cell_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cell_bank_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [cell_bank_pkg::NSRC-2:0] ext_src,
    input wire logic fast_internal_osc,
    output logic [cell_bank_pkg::NCELL-1:0] cell_output_bit,
    output logic fast_osc_keep_on,
    output logic irq
);
    import cell_bank_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [NSRC-1:0] src;
    logic [NCELL-1:0] cell_y;
    cell_ctrl_t ctrl_q [NCELL];
    cell_route_t route_q [NCELL];
    logic [NCELL-1:0] out_q;
    logic [NCELL-1:0] rise;
    logic [NCELL-1:0] fall;
    logic [NCELL-1:0] flag_set;
    logic [NCELL-1:0] flag_clr;
    logic [NCELL-1:0] cell_irq_flag_q;
    logic [NCELL-1:0] cell_irq_enable_q;
    logic global_irq_enable_q;
    logic peripheral_irq_enable_q;
    logic [NCELL-1:0] osc_use;
    logic wr_go;
    logic rd_go;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [2:0] wr_cell;
    logic [2:0] rd_cell;
    logic wr_in_cell;
    logic rd_in_cell;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] ctrl_word(
        input cell_ctrl_t c,
        input logic o
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        r[CTRL_EN] = c.enable;
        r[CTRL_OUT] = o;
        r[CTRL_RISE] = c.rise_irq_enable;
        r[CTRL_FALL] = c.fall_irq_enable;
        r[CTRL_MODE_LSB +: 3] = c.logic_function_field;
        return r;
    endfunction

    function automatic logic [31:0] pol_word(input cell_route_t rt);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[POL_OUT] = rt.output_invert_bit;
        r[NGATE-1:0] = rt.gate_invert_bit;
        return r;
    endfunction

    // ==========================================================
    // Cells
    // ==========================================================
    assign src = {fast_internal_osc, ext_src};

    generate
        for (genvar i = 0; i < NCELL; i++) begin : g_cell
            logic [31:0] cw;
            logic [31:0] sw;
            logic [31:0] gw;
            logic [31:0] pw;
            logic wr_me;

            assign wr_me = wr_go && wr_in_cell &&
                (wr_cell == 3'(i + 1));

            // [RULE_08] Clockless cell datapath.
            logic_cell u_cell (
                .src(src),
                .ctrl(ctrl_q[i]),
                .route(route_q[i]),
                .y(cell_y[i])
            );

            always_comb begin
                cw = merge(ctrl_word(ctrl_q[i], out_q[i]),
                    s_axi_wdata, s_axi_wstrb);
                sw = merge({20'h0_0000, route_q[i].input_select},
                    s_axi_wdata, s_axi_wstrb);
                gw = merge({16'h0000, route_q[i].gate_source},
                    s_axi_wdata, s_axi_wstrb);
                pw = merge(pol_word(route_q[i]),
                    s_axi_wdata, s_axi_wstrb);
            end

            // [RULE_07] Control cleared on reset.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ctrl_q[i] <= cell_ctrl_t'(CTRL_RESET[5:0]);
                end else if (wr_me && s_axi_awaddr[3:2] == OFS_CTRL) begin
                    ctrl_q[i].enable <= cw[CTRL_EN];
                    ctrl_q[i].rise_irq_enable <= cw[CTRL_RISE];
                    ctrl_q[i].fall_irq_enable <= cw[CTRL_FALL];
                    ctrl_q[i].logic_function_field <=
                        cw[CTRL_MODE_LSB +: 3];
                end
            end

            // [RULE_07] Routing survives reset.
            always_ff @(posedge aclk) begin
                if (wr_me) begin
                    case (s_axi_awaddr[3:2])
                        OFS_SEL: route_q[i].input_select <= sw[11:0];
                        OFS_GLS: route_q[i].gate_source <= gw[15:0];
                        OFS_POL: begin
                            route_q[i].gate_invert_bit <= pw[NGATE-1:0];
                            route_q[i].output_invert_bit <= pw[POL_OUT];
                        end
                        default: ;
                    endcase
                end
            end

            // [RULE_09] Fast oscillator demand.
            always_comb begin
                osc_use[i] = 1'b0;
                for (int k = 0; k < NGATE; k++) begin
                    if (route_q[i].input_select[k] == SRC_FAST_OSC) begin
                        osc_use[i] = ctrl_q[i].enable;
                    end
                end
            end

            // [RULE_01] Rise and fall detectors.
            assign rise[i] = cell_y[i] & ~out_q[i];
            assign fall[i] = ~cell_y[i] & out_q[i];

            // [RULE_02] Edge gated by its enable.
            assign flag_set[i] =
                (rise[i] & ctrl_q[i].rise_irq_enable) |
                (fall[i] & ctrl_q[i].fall_irq_enable);
        end
    endgenerate

    assign cell_output_bit = cell_y;
    assign fast_osc_keep_on = |osc_use;

    // ==========================================================
    // Output snapshot
    // ==========================================================
    // [RULE_12] Previous output register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= '0;
        end else begin
            out_q <= cell_y;
        end
    end

    // ==========================================================
    // Interrupt flags and enables
    // ==========================================================
    assign flag_clr = (wr_go && s_axi_awaddr == ADDR_FLAG &&
        s_axi_wstrb[0]) ? s_axi_wdata[NCELL-1:0] : '0;

    // [RULE_04] Set wins over clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cell_irq_flag_q <= FLAG_RESET;
        end else begin
            cell_irq_flag_q <= (cell_irq_flag_q & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cell_irq_enable_q <= IEN_RESET;
        end else if (wr_go && s_axi_awaddr == ADDR_IEN &&
                s_axi_wstrb[0]) begin
            cell_irq_enable_q <= s_axi_wdata[NCELL-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_irq_enable_q <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
        end else if (wr_go && s_axi_awaddr == ADDR_INTCTL &&
                s_axi_wstrb[0]) begin
            global_irq_enable_q <= s_axi_wdata[INTCTL_GIE];
            peripheral_irq_enable_q <= s_axi_wdata[INTCTL_PERIPHERAL_IRQ_ENABLE];
        end
    end

    // [RULE_05] All enables gate the request.
    assign irq = (|(cell_irq_flag_q & cell_irq_enable_q)) &
        peripheral_irq_enable_q & global_irq_enable_q;

    // ==========================================================
    // Address decode
    // ==========================================================
    assign wr_cell = s_axi_awaddr[6:4];
    assign rd_cell = s_axi_araddr[6:4];
    assign wr_in_cell = !s_axi_awaddr[7] && wr_cell >= 3'h1 &&
        wr_cell <= 3'(NCELL);
    assign rd_in_cell = !s_axi_araddr[7] && rd_cell >= 3'h1 &&
        rd_cell <= 3'(NCELL);
    assign wr_hit = wr_in_cell || s_axi_awaddr == ADDR_INTCTL ||
        s_axi_awaddr == ADDR_FLAG || s_axi_awaddr == ADDR_IEN ||
        s_axi_awaddr == ADDR_MIRROR;

    // ==========================================================
    // Read mux
    // ==========================================================
    always_comb begin
        logic [1:0] ci;
        ci = 2'(rd_cell - 3'h1);
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (rd_in_cell) begin
            case (s_axi_araddr[3:2])
                OFS_CTRL: rd_word = ctrl_word(ctrl_q[ci], out_q[ci]);
                OFS_SEL: rd_word[11:0] = route_q[ci].input_select;
                OFS_GLS: rd_word[15:0] = route_q[ci].gate_source;
                default: rd_word = pol_word(route_q[ci]);
            endcase
        end else begin
            case (s_axi_araddr)
                ADDR_INTCTL: begin
                    rd_word[INTCTL_GIE] = global_irq_enable_q;
                    rd_word[INTCTL_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_q;
                end
                ADDR_FLAG: rd_word[NCELL-1:0] = cell_irq_flag_q;
                ADDR_IEN: rd_word[NCELL-1:0] = cell_irq_enable_q;
                // [RULE_06] One-instant output copy.
                ADDR_MIRROR: rd_word[NCELL-1:0] = out_q;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite write channel
    // ==========================================================
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    // ==========================================================
    assign rd_go = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// [bench/cell_bank_asserts.sv]
// Concurrent checks on the ports of the logic cell bank.
`timescale 1ns/1ps
module cell_bank_asserts
    import cell_bank_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [cell_bank_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [cell_bank_pkg::NCELL-1:0] cell_output_bit,
    input wire logic fast_osc_keep_on,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid
        && s_axi_awready |=> s_axi_bvalid)
        else $error("write taken without a response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read taken without an answer");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before it was taken");
    a_unmapped_error: assert property ($rose(s_axi_rvalid)
        && $past(s_axi_araddr) >= 8'h50
        |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mirror_snapshot: assert property ($rose(s_axi_rvalid)
        && $past(s_axi_araddr) == ADDR_MIRROR
        |-> s_axi_rdata[NCELL-1:0] == $past(cell_output_bit, 2))
        else $error("mirror read differs from cell outputs");
    a_irq_cause: assert property ($rose(irq)
        |-> $rose(s_axi_bvalid)
        || $past(cell_output_bit) != $past(cell_output_bit, 2))
        else $error("interrupt raised without an edge or a write");
    a_osc_hold_cause: assert property ($changed(fast_osc_keep_on)
        |-> $rose(s_axi_bvalid))
        else $error("oscillator hold changed without a write");
    a_reset_idle: assert property (disable iff (1'h0) !aresetn
        |=> cell_output_bit == '0 && !fast_osc_keep_on && !irq)
        else $error("outputs not idle after reset");
endmodule

bind cell_bank cell_bank_asserts chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cell_output_bit, .fast_osc_keep_on,
    .irq);

// [bench/irq_host_model.sv]
// Processor interrupt entry model that counts raised requests.
`timescale 1ns/1ps
module irq_host_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic irq,
    output int unsigned taken
);
    logic seen_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_q <= 1'h0;
            taken <= 0;
        end else begin
            seen_q <= irq;
            if (irq && !seen_q) begin
                taken <= taken + 1;
            end
        end
    end
endmodule

// [bench/test_cell_bank.sv]
// Self-checking bench for the logic cell bank and its interrupt host.
`timescale 1ns/1ps
module test_cell_bank;
    import cell_bank_pkg::*;
    logic aclk, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
    logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, fosc = 1'h0;
    logic [ADDR_W-1:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [6:0] ext_src = 7'h0;
    logic awready, wready, bvalid, arready, rvalid, keep_on, irq;
    logic [1:0] bresp, rresp;
    logic [NCELL-1:0] cout;
    logic [33:0] notes[$];
    int err_total = 0, compares = 0, cycles = 0;
    int unsigned taken;

    cell_bank dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_src(ext_src), .fast_internal_osc(fosc),
        .cell_output_bit(cout), .fast_osc_keep_on(keep_on), .irq(irq)
    );
    irq_host_model host (.aclk(aclk), .aresetn(aresetn), .irq(irq),
        .taken(taken));

    // ==========================================================
    // Clock, timeout and helpers
    // ==========================================================
    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [33:0] seen,
                       input logic [33:0] expv);
        compares++;
        if (seen !== expv) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, expv, seen);
        end
    endtask

    function automatic logic [ADDR_W-1:0] ca(input int i, input logic [1:0] o);
        return 8'(CELL_BASE + CELL_STRIDE * i + 4 * o);
    endfunction

    function automatic logic fexp(input logic [2:0] m, input logic [3:0] v);
        case (m)
            MODE_AND_OR: return (v[0] & v[1]) | (v[2] & v[3]);
            MODE_OR_XOR: return (v[0] | v[1]) ^ (v[2] | v[3]);
            MODE_AND4: return &v;
            MODE_OR4: return |v;
            MODE_XOR4: return ^v;
            default: return 1'h0;
        endcase
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        notes.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do @(posedge aclk); while ((awready & wready) !== 1'h1);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h1;
        @(posedge aclk);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        notes.push_back({r, d});
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h1;
        @(posedge aclk);
        rready <= 1'h0;
    endtask

    // Takes the oldest note whenever a bus answer is accepted.
    always @(posedge aclk) begin
        if (rvalid === 1'h1 && rready === 1'h1) begin
            chk("read answer", {rresp, rdata}, notes.pop_front());
        end
        if (bvalid === 1'h1 && bready === 1'h1) begin
            chk("write response", {bresp, 32'h0}, notes.pop_front());
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'h61F1));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(ADDR_INTCTL, 32'h0, RESP_OKAY);
        rd(ADDR_FLAG, 32'(FLAG_RESET), RESP_OKAY);
        rd(ADDR_IEN, 32'(IEN_RESET), RESP_OKAY);
        rd(ca(0, OFS_CTRL), CTRL_RESET, RESP_OKAY);
        rd(8'h50, 32'h0, RESP_SLVERR);
        wr(8'h54, 32'h1, RESP_SLVERR);
        $display("test reset values done");
        wr(ca(0, OFS_CTRL), 32'h0, RESP_OKAY);
        wr(ca(0, OFS_SEL), 32'h688, RESP_OKAY);
        wr(ca(0, OFS_GLS), 32'h8421, RESP_OKAY);
        wr(ca(0, OFS_POL), 32'h0, RESP_OKAY);
        for (int m = 0; m < 6; m++) begin
            wr(ca(0, OFS_CTRL), 32'(m), RESP_OKAY);
            wr(ca(0, OFS_CTRL), 32'h80 | 32'(m), RESP_OKAY);
            repeat (4) begin
                ext_src <= 7'($urandom);
                #1;
                chk("cell output", 34'(cout[0]),
                    34'(fexp(3'(m), ext_src[3:0])));
                @(posedge aclk);
            end
        end
        wr(ca(0, OFS_CTRL), 32'h05, RESP_OKAY);
        wr(ca(0, OFS_POL), 32'h80, RESP_OKAY);
        wr(ca(0, OFS_CTRL), 32'h85, RESP_OKAY);
        chk("inverted output", 34'(cout[0]), 34'h1);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("outputs after reset", 34'(cout), 34'h0);
        rd(ca(0, OFS_CTRL), CTRL_RESET, RESP_OKAY);
        rd(ca(0, OFS_POL), 32'h80, RESP_OKAY);
        rd(ca(0, OFS_SEL), 32'h688, RESP_OKAY);
        rd(ca(0, OFS_GLS), 32'h8421, RESP_OKAY);
        $display("test functions and reset done");
        wr(ca(0, OFS_POL), 32'h0, RESP_OKAY);
        ext_src <= 7'h0;
        wr(ca(0, OFS_CTRL), 32'h93, RESP_OKAY);
        wr(ADDR_FLAG, 32'hF, RESP_OKAY);
        wr(ADDR_IEN, 32'h1, RESP_OKAY);
        wr(ADDR_INTCTL, 32'h3, RESP_OKAY);
        rd(ADDR_FLAG, 32'h0, RESP_OKAY);
        ext_src <= 7'h1;
        repeat (3) @(posedge aclk);
        chk("irq on rise", 34'(irq), 34'h1);
        chk("host entries", 34'(taken), 34'h1);
        rd(ADDR_FLAG, 32'h1, RESP_OKAY);
        wr(ADDR_FLAG, 32'h1, RESP_OKAY);
        ext_src <= 7'h0;
        repeat (3) @(posedge aclk);
        rd(ADDR_FLAG, 32'h0, RESP_OKAY);
        ext_src <= 7'h1;
        repeat (3) @(posedge aclk);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_INTCTL, (k == 0) ? 32'h2 : (k == 1) ? 32'h1 : 32'h3,
               RESP_OKAY);
            wr(ADDR_IEN, (k == 2) ? 32'h0 : 32'h1, RESP_OKAY);
            chk("irq gating", 34'(irq), 34'(k == 3));
        end
        wr(ca(0, OFS_CTRL), 32'h9B, RESP_OKAY);
        ext_src <= 7'h0;
        wr(ADDR_FLAG, 32'h1, RESP_OKAY);
        rd(ADDR_FLAG, 32'h1, RESP_OKAY);
        wr(ADDR_FLAG, 32'h1, RESP_OKAY);
        rd(ADDR_FLAG, 32'h0, RESP_OKAY);
        $display("test interrupts done");
        wr(ca(1, OFS_SEL), 32'h7, RESP_OKAY);
        wr(ca(1, OFS_GLS), 32'h1, RESP_OKAY);
        wr(ca(1, OFS_POL), 32'h0, RESP_OKAY);
        chk("osc hold idle", 34'(keep_on), 34'h0);
        wr(ca(1, OFS_CTRL), 32'h83, RESP_OKAY);
        chk("osc hold on", 34'(keep_on), 34'h1);
        repeat (6) begin
            ext_src <= 7'($urandom);
            fosc <= 1'($urandom);
            repeat (2) @(posedge aclk);
            chk("pin drive", 34'(cout[1]), 34'(fosc));
            rd(ADDR_MIRROR, 32'({fosc, |ext_src[3:0]}), RESP_OKAY);
        end
        wr(ca(1, OFS_CTRL), 32'h0, RESP_OKAY);
        chk("osc hold off", 34'(keep_on), 34'h0);
        $display("test mirror and oscillator done");
        stop_test();
    end
endmodule
